//--- design/duc_defines.svh
// Timing and layout constants for the DAC update and busy control block
`ifndef DUC_DEFINES_SVH
`define DUC_DEFINES_SVH
`define DUC_CLK_MHZ        25
`define DUC_CLR_US_16CH    20
`define DUC_CLR_US_8CH     15
`define DUC_RST_US         270
`define DUC_CLR_CYC_16CH   (`DUC_CLR_US_16CH * `DUC_CLK_MHZ)
`define DUC_CLR_CYC_8CH    (`DUC_CLR_US_8CH * `DUC_CLK_MHZ)
`define DUC_RST_CYC        (`DUC_RST_US * `DUC_CLK_MHZ)
`define DUC_CALC_CYC       16
`define DUC_FRAME_BITS     24
`define DUC_MON_EXT0       5'h10
`define DUC_MON_EXT1       5'h11
`define DUC_CLR_CODE_RST   14'h0000
`endif

//--- design/duc_pkg.sv
// Types shared by the DAC update and busy control block
package duc_pkg;
  typedef enum logic [4:0] {
    DUC_IDLE  = 5'b0_0001,
    DUC_CALC  = 5'b0_0010,
    DUC_LOAD  = 5'b0_0100,
    DUC_CLEAR = 5'b0_1000,
    DUC_RESET = 5'b1_0000
  } duc_state_e;
endpackage

//--- design/duc_queue_if.sv
// Write queue carrier between top and memory module
`timescale 1ns/1ps
interface duc_queue_if #(parameter int DW = 24);
  logic          wr_en;
  logic [DW-1:0] wr_data;
  logic          rd_en;
  logic [DW-1:0] rd_data;
  logic          empty;
  logic          full;
  modport owner (output wr_en, output wr_data, output rd_en,
                 input rd_data, input empty, input full);
  modport store (input wr_en, input wr_data, input rd_en,
                 output rd_data, output empty, output full);
endinterface

//--- design/duc_queue_mem.sv
// Small queue memory holding register writes made while busy
`timescale 1ns/1ps
module duc_queue_mem #(
  parameter int DW    = 24,
  parameter int DEPTH = 8
) (
  input  wire logic  clk_i,   // Clock
  input  wire logic  nrst_i,  // Async reset, active low
  input  wire logic  en_i,    // Clock enable
  input  wire logic  flush_i, // Empty the queue
  duc_queue_if.store q        // Queue port
);
  localparam int AW = $clog2(DEPTH);
  logic [DW-1:0] mem [DEPTH];
  logic [AW:0]   wp_r;
  logic [AW:0]   rp_r;
  logic [DW-1:0] rd_r;
  logic          do_wr;
  logic          do_rd;

  assign q.empty   = (wp_r == rp_r);
  assign q.full    = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
  assign q.rd_data = rd_r;
  assign do_wr     = en_i && q.wr_en && !q.full && !flush_i;
  assign do_rd     = en_i && q.rd_en && !q.empty && !flush_i;

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wp_r[AW-1:0]] <= q.wr_data;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      rd_r <= '0;
    end else if (en_i) begin
      if (flush_i) begin
        wp_r <= '0;
        rp_r <= '0;
      end else begin
        if (do_wr) begin
          wp_r <= wp_r + 1'b1;
        end
        if (do_rd) begin
          rp_r <= rp_r + 1'b1;
          rd_r <= mem[rp_r[AW-1:0]];
        end
      end
    end
  end
endmodule

//--- design/duc_top.sv
// DAC update, busy, clear and reset control with serial framing
//
// Function
// - Frame sync low starts bit counter; register updates after full frame counted
// - Two-wire mode uses frame sync and chain pins as address bits
// - Four-wire mode: chain enable high cascades data to readback output
// - Readback shifted on clock rise, tristated when idle; host samples on fall
// - Busy low while computing a channel's corrected data word
// - Writes during calculation queue in FIFO; DAC updates blocked
// - Load request while not busy transfers input registers to DAC immediately
// - Load request during calculation is stored, applied when busy returns high
// - During reset busy low, interfaces disabled, load events discarded
// - Clear acts on falling edge; load pulses ignored while clear low
// - Clear loads clear code to all channels; busy 20 or 15 us
// - Reset falling edge starts power-on equivalent register reset sequence
// - Reset sequence 270 us max, busy low throughout, then high
// - After reset, pin level ignored until next falling edge
// - Reference pin defaults to input; control bit selects internal drive
// - Monitor enabled routes any selected channel to monitor output
// - Monitor selector can route either external monitor input
// - Interface select high chooses four-wire, low chooses two-wire
// - Serial interface keeps working while power-down is high
`timescale 1ns/1ps
`include "duc_defines.svh"
module duc_top
  import duc_pkg::*;
#(
  parameter int          CHANNELS = 16,
  parameter int          FRAME    = `DUC_FRAME_BITS,
  parameter int          CALC_CYC = `DUC_CALC_CYC,
  parameter int unsigned RST_CYC  = `DUC_RST_CYC,
  parameter int          QDEPTH   = 8
) (
  input  wire logic        clk_i,                   // Clock 25 MHz
  input  wire logic        nrst_i,                  // Async reset, active low
  input  wire logic        en_i,                    // Clock enable
  input  wire logic        sclk_i,                  // Serial clock pin
  input  wire logic        frame_sync_addr_bit0_i,  // Frame sync / address bit 0
  input  wire logic        chain_enable_addr_bit1_i, // Chain enable / address bit 1
  input  wire logic        din_i,                   // Serial data in
  input  wire logic        if_sel_i,                // High four-wire, low two-wire
  input  wire logic        power_down_in_i,         // Power-down level
  input  wire logic        load_outputs_n_i,        // Load outputs, active low
  input  wire logic        clear_to_code_n_i,       // Clear to code, active low
  input  wire logic        reset_n_i,               // Digital reset pin, active low
  input  wire logic        int_ref_sel_i,           // Select internal reference
  input  wire logic        mon_en_i,                // Monitor enable
  input  wire logic [4:0]  mon_sel_i,               // Monitor source select
  input  wire logic [13:0] clear_code_i,            // Clear code value
  output logic             serial_readback_out_o,   // Readback data
  output logic             serial_readback_oe_o,    // Readback drive enable
  output logic             busy_n_o,                // Busy, low while working
  output logic [1:0]       bus_addr_bits_o,         // Two-wire address bits
  output logic             frame_done_o,            // Frame counted, pulse
  output logic [FRAME-1:0] frame_word_o,            // Received frame word
  output logic             dac_load_o,              // Input to DAC transfer, pulse
  output logic             clear_load_o,            // Clear code load, pulse
  output logic [13:0]      clear_value_o,           // Code loaded on clear
  output logic             regs_reset_o,            // Registers to defaults, level
  output logic             reference_pin_oe_o,      // Reference pin driven
  output logic             mon_path_en_o,           // Monitor switch closed
  output logic [4:0]       monitor_output_sel_o     // Monitor source routed
);
  localparam int          CW      = $clog2(FRAME + 1);
  localparam int unsigned CLR_CYC = (CHANNELS > 8) ? `DUC_CLR_CYC_16CH : `DUC_CLR_CYC_8CH;
  // Shared countdown must hold the longest of the reset, clear and calculation spans
  localparam int unsigned T_MAX1  = (RST_CYC > CLR_CYC) ? RST_CYC : CLR_CYC;
  localparam int unsigned T_MAX   = (T_MAX1 > CALC_CYC) ? T_MAX1 : CALC_CYC;
  localparam int          TW      = $clog2(T_MAX + 1);

  typedef struct packed {
    logic [1:0]       sclk_s;
    logic [1:0]       sync_s;
    logic [1:0]       dcen_s;
    logic [1:0]       din_s;
    logic [1:0]       load_outputs_n_s;
    logic [1:0]       clr_s;
    logic [1:0]       rst_s;
    logic [1:0]       isel_s;
    logic             sclk_d;
    logic             load_outputs_n_d;
    logic             clr_d;
    logic             rst_d;
    logic [CW-1:0]    bits;
    logic [FRAME-1:0] shreg;
    logic             serial_readback_out;
    logic             sdo_oe;
    logic             pend;
    logic [TW-1:0]    timer;
    duc_state_e       st;
    logic             done;
    logic [FRAME-1:0] word;
    logic             load;
    logic             cload;
    logic [13:0]      cval;
  } duc_s;

  duc_s r_r;
  duc_s r_nxt;

  duc_queue_if #(.DW(FRAME)) q ();
  duc_queue_mem #(.DW(FRAME), .DEPTH(QDEPTH)) u_queue (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .en_i    (en_i),
    .flush_i (r_r.st == DUC_RESET),
    .q       (q.store)
  );

  function automatic logic fell(input logic prev, input logic now);
    fell = prev && !now;
  endfunction

  // Last cycle of any countdown
  function automatic logic last_tick(input logic [TW-1:0] t);
    last_tick = (t == TW'(1));
  endfunction

  logic sclk_rise;
  logic sclk_fall;
  logic load_outputs_n_fall;
  logic clr_fall;
  logic rst_fall;
  logic spi_mode;
  logic iface_on;
  logic calc_end;

  always_comb begin
    sclk_rise = !r_r.sclk_d && r_r.sclk_s[1];
    sclk_fall = fell(r_r.sclk_d, r_r.sclk_s[1]);
    load_outputs_n_fall = fell(r_r.load_outputs_n_d, r_r.load_outputs_n_s[1]);
    clr_fall  = fell(r_r.clr_d, r_r.clr_s[1]);
    rst_fall  = fell(r_r.rst_d, r_r.rst_s[1]);
    spi_mode  = r_r.isel_s[1];
    iface_on  = (r_r.st != DUC_RESET) && (r_r.st != DUC_CLEAR);
    calc_end  = (r_r.st == DUC_CALC) && last_tick(r_r.timer);
  end

  // Queued writes handed to the calculation engine one at a time
  always_comb begin
    q.wr_en   = r_nxt.done;
    q.wr_data = r_nxt.word;
    q.rd_en   = (r_r.st == DUC_IDLE) && !q.empty;
  end

  always_comb begin
    r_nxt        = r_r;
    r_nxt.sclk_s = {r_r.sclk_s[0], sclk_i};
    r_nxt.sync_s = {r_r.sync_s[0], frame_sync_addr_bit0_i};
    r_nxt.dcen_s = {r_r.dcen_s[0], chain_enable_addr_bit1_i};
    r_nxt.din_s  = {r_r.din_s[0], din_i};
    r_nxt.load_outputs_n_s = {r_r.load_outputs_n_s[0], load_outputs_n_i};
    r_nxt.clr_s  = {r_r.clr_s[0], clear_to_code_n_i};
    r_nxt.rst_s  = {r_r.rst_s[0], reset_n_i};
    r_nxt.isel_s = {r_r.isel_s[0], if_sel_i};
    r_nxt.sclk_d = r_r.sclk_s[1];
    r_nxt.load_outputs_n_d = r_r.load_outputs_n_s[1];
    r_nxt.clr_d  = r_r.clr_s[1];
    r_nxt.rst_d  = r_r.rst_s[1];
    r_nxt.done   = 1'b0;
    r_nxt.load   = 1'b0;
    r_nxt.cload  = 1'b0;

    if (!spi_mode || !iface_on || r_r.sync_s[1]) begin
      r_nxt.bits   = '0;
      r_nxt.sdo_oe = 1'b0;
    end else begin
      r_nxt.sdo_oe = 1'b1;
      if (sclk_fall) begin
        r_nxt.shreg = {r_r.shreg[FRAME-2:0], r_r.din_s[1]};
        if (r_r.bits == CW'(FRAME - 1)) begin
          r_nxt.bits = '0;
          r_nxt.done = 1'b1;
          r_nxt.word = {r_r.shreg[FRAME-2:0], r_r.din_s[1]};
        end else begin
          r_nxt.bits = r_r.bits + 1'b1;
        end
      end
      // chain cascade
      // First cycle of a frame puts the held MSB out before the first falling edge
      if (sclk_rise || !r_r.sdo_oe) begin
        r_nxt.serial_readback_out = r_r.dcen_s[1] ? r_r.shreg[FRAME-1] : 1'b0;
      end
    end

    if (load_outputs_n_fall && r_r.clr_s[1] && iface_on) begin
      r_nxt.pend = 1'b1;
    end

    case (r_r.st)
      DUC_IDLE: begin
        if (!q.empty) begin
          r_nxt.st    = DUC_CALC;
          r_nxt.timer = TW'(CALC_CYC);
        end else if (r_r.pend || r_nxt.pend) begin
          r_nxt.st = DUC_LOAD;
        end
      end
      DUC_CALC: begin
        r_nxt.timer = r_r.timer - 1'b1;
        if (calc_end) begin
          r_nxt.st = DUC_IDLE;
        end
      end
      DUC_LOAD: begin
        r_nxt.load = 1'b1;
        r_nxt.pend = load_outputs_n_fall && r_r.clr_s[1];
        r_nxt.st   = DUC_IDLE;
      end
      DUC_CLEAR: begin
        r_nxt.timer = r_r.timer - 1'b1;
        if (last_tick(r_r.timer)) begin
          r_nxt.st = DUC_IDLE;
        end
      end
      DUC_RESET: begin
        r_nxt.timer = r_r.timer - 1'b1;
        if (last_tick(r_r.timer)) begin
          r_nxt.st = DUC_IDLE;
        end
      end
      default: begin
        r_nxt.st = DUC_IDLE;
      end
    endcase

    if (clr_fall && r_r.st != DUC_RESET) begin
      r_nxt.st    = DUC_CLEAR;
      r_nxt.timer = TW'(CLR_CYC);
      r_nxt.cload = 1'b1;
      r_nxt.cval  = clear_code_i;
    end
    if (rst_fall) begin
      r_nxt.st    = DUC_RESET;
      r_nxt.timer = TW'(RST_CYC);
      r_nxt.pend  = 1'b0;
      r_nxt.load  = 1'b0;
      r_nxt.cload = 1'b0;
      r_nxt.bits  = '0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_r        <= '0;
      // Serial clock idles high, so no false edge after reset
      r_r.sclk_s <= 2'h3;
      r_r.sclk_d <= 1'b1;
      r_r.isel_s <= 2'h3;
      r_r.sync_s <= 2'h3;
      r_r.load_outputs_n_s <= 2'h3;
      r_r.clr_s  <= 2'h3;
      r_r.rst_s  <= 2'h3;
      r_r.load_outputs_n_d <= 1'b1;
      r_r.clr_d  <= 1'b1;
      r_r.rst_d  <= 1'b1;
      r_r.cval   <= `DUC_CLR_CODE_RST;
      r_r.st     <= DUC_RESET;
      r_r.timer  <= TW'(RST_CYC);
    end else if (en_i) begin
      r_r <= r_nxt;
    end
  end

  always_comb begin
    serial_readback_out_o = r_r.serial_readback_out;
    serial_readback_oe_o  = r_r.sdo_oe;
    busy_n_o              = (r_r.st == DUC_IDLE);
    bus_addr_bits_o       = spi_mode ? 2'h0 : {r_r.dcen_s[1], r_r.sync_s[1]};
    frame_done_o          = r_r.done;
    frame_word_o          = r_r.word;
    dac_load_o            = r_r.load;
    clear_load_o          = r_r.cload;
    clear_value_o         = r_r.cval;
    regs_reset_o          = (r_r.st == DUC_RESET);
    reference_pin_oe_o    = int_ref_sel_i;
    mon_path_en_o         = mon_en_i && ((mon_sel_i < 5'(CHANNELS))
                            || (mon_sel_i == `DUC_MON_EXT0) || (mon_sel_i == `DUC_MON_EXT1));
    monitor_output_sel_o  = mon_sel_i;
  end
endmodule

//--- sim/duc_host_model.sv
// Serial host model that sends frames and collects readback bits
`timescale 1ns/1ps
module duc_host_model #(
  parameter int HALF = 160
) (
  input  wire logic sdo_i,    // Readback pin
  input  wire logic oe_i,     // Readback drive enable
  output logic      sclk_o,   // Serial clock, idle high
  output logic      sync_n_o, // Frame sync
  output logic      din_o     // Serial data
);
  logic [23:0] rd_word;
  logic        last_v = 1'b0;
  // Undriven line shows the inverse of its last value
  wire         line_w = oe_i ? sdo_i : ~last_v;
  initial begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic send(input logic [23:0] w);
    sync_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      din_o = w[i];
      #HALF sclk_o = 1'b0;
      last_v = line_w;
      rd_word = {rd_word[22:0], line_w};
      #HALF sclk_o = 1'b1;
    end
    #HALF sync_n_o = 1'b1;
    din_o = ~din_o;
    #HALF;
  endtask
endmodule

//--- sim/duc_top_assertions.sv
// Port checks on the DAC update and busy control block
`timescale 1ns/1ps
module duc_top_checker #(
  parameter int unsigned RST_CYC  = 50,
  parameter int          CHANNELS = 16
) (
  input wire logic       clk_i,                // Clock
  input wire logic       nrst_i,               // Reset
  input wire logic       int_ref_sel_i,        // Reference select
  input wire logic       mon_en_i,             // Monitor enable
  input wire logic [4:0] mon_sel_i,            // Monitor select
  input wire logic       busy_n_o,             // Busy
  input wire logic       frame_done_o,         // Frame done
  input wire logic       dac_load_o,           // DAC load
  input wire logic       clear_load_o,         // Clear load
  input wire logic       regs_reset_o,         // Reset sequence
  input wire logic       reference_pin_oe_o,   // Reference drive
  input wire logic       mon_path_en_o,        // Monitor path
  input wire logic [4:0] monitor_output_sel_o  // Monitor route
);
  logic [15:0] rst_cnt_r;
  logic        mon_exp;
  // Channels below the count, or either external input code
  assign mon_exp = mon_en_i && ((mon_sel_i < 5'(CHANNELS)) || (mon_sel_i == 5'h10)
                   || (mon_sel_i == 5'h11));
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) rst_cnt_r <= 16'h0000;
    else if (regs_reset_o) rst_cnt_r <= rst_cnt_r + 16'h0001;
    else rst_cnt_r <= 16'h0000;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  reset_busy_a: assert property (regs_reset_o |-> !busy_n_o)
    else $error("busy high in reset sequence");
  reset_length_a: assert property (rst_cnt_r <= RST_CYC + 4)
    else $error("reset sequence too long");
  reset_end_a: assert property ($fell(regs_reset_o) |-> ##[0:3] busy_n_o)
    else $error("busy not back after reset");
  clear_busy_a: assert property (clear_load_o |=> !busy_n_o [*8])
    else $error("busy high during clear");
  frame_calc_a: assert property (frame_done_o && busy_n_o |-> ##[1:8] !busy_n_o)
    else $error("no calculation after frame");
  load_reset_a: assert property (dac_load_o |-> !regs_reset_o)
    else $error("load during reset");
  ref_pin_a: assert property (reference_pin_oe_o == int_ref_sel_i)
    else $error("reference drive wrong");
  mon_route_a: assert property (
      mon_path_en_o == mon_exp && monitor_output_sel_o == mon_sel_i)
    else $error("monitor route wrong");
  load_c: cover property (dac_load_o);
  frame_c: cover property (frame_done_o);
  clear_c: cover property (clear_load_o);
endmodule
bind duc_top duc_top_checker #(.RST_CYC(RST_CYC), .CHANNELS(CHANNELS)) chk_u (.clk_i, .nrst_i,
  .int_ref_sel_i,
  .mon_en_i, .mon_sel_i, .busy_n_o, .frame_done_o, .dac_load_o, .clear_load_o,
  .regs_reset_o, .reference_pin_oe_o, .mon_path_en_o, .monitor_output_sel_o);

//--- sim/test_duc_top.sv
// Self-checking bench for the DAC update and busy control block
`timescale 1ns/1ps
module test_duc_top;
  localparam int unsigned RST = 50;
  logic clk_i = 1'b0, nrst_i = 1'b0, en_i = 1'b1, if_sel_i = 1'b1, power_down_in_i = 1'b1;
  logic load_outputs_n_i = 1'b1, clear_to_code_n_i = 1'b1, reset_n_i = 1'b1, addr0 = 1'b0;
  logic int_ref_sel_i = 1'b0, mon_en_i = 1'b1, chain_enable_addr_bit1_i = 1'b0;
  logic [4:0]  mon_sel_i = 5'h00;
  logic [13:0] clear_code_i = 14'h2A5C;
  logic [4:0]  sels [5] = '{5'h00, 5'h07, 5'h0F, 5'h10, 5'h11};
  logic sclk_i, din_i, hsync, frame_sync_addr_bit0_i, serial_readback_out_o;
  logic serial_readback_oe_o, busy_n_o, frame_done_o, dac_load_o, clear_load_o;
  logic regs_reset_o, reference_pin_oe_o, mon_path_en_o;
  logic [1:0]  bus_addr_bits_o;
  logic [23:0] frame_word_o;
  logic [13:0] clear_value_o, cl_val;
  logic [4:0]  monitor_output_sel_o;
  int num_errors = 0, cmp_count = 0, cyc = 0, dl = 0, fd = 0, cl = 0, n, d0;
  always #20 clk_i = ~clk_i;
  assign frame_sync_addr_bit0_i = if_sel_i ? hsync : addr0;
  duc_top #(.RST_CYC(RST)) dut_u (.clk_i, .nrst_i, .en_i, .sclk_i, .frame_sync_addr_bit0_i,
    .chain_enable_addr_bit1_i, .din_i, .if_sel_i, .power_down_in_i, .load_outputs_n_i,
    .clear_to_code_n_i, .reset_n_i, .int_ref_sel_i, .mon_en_i, .mon_sel_i, .clear_code_i,
    .serial_readback_out_o, .serial_readback_oe_o, .busy_n_o, .bus_addr_bits_o,
    .frame_done_o, .frame_word_o, .dac_load_o, .clear_load_o, .clear_value_o,
    .regs_reset_o, .reference_pin_oe_o, .mon_path_en_o, .monitor_output_sel_o);
  duc_host_model host_u (.sdo_i(serial_readback_out_o), .oe_i(serial_readback_oe_o),
    .sclk_o(sclk_i), .sync_n_o(hsync), .din_o(din_i));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_busy();
    n = 0;
    while (busy_n_o !== 1'b1 && n < 5000) begin
      step(1);
      n++;
    end
  endtask
  task automatic pulse_load();
    load_outputs_n_i = 1'b0;
    step(3);
    load_outputs_n_i = 1'b1;
  endtask
  task automatic frame(input logic [23:0] w, input logic ld);
    d0 = dl;
    fork
      host_u.send(w);
    join_none
    n = 0;
    while (frame_done_o !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    step(3);
    check("frame_word", frame_word_o, w);
    check("busy_calc", busy_n_o, 0);
    if (ld) begin
      pulse_load();
      check("load_held", dl, d0);
      wait_busy();
      step(6);
      check("load_after", dl, d0 + 1);
    end
    step(20);
    check("sdo_idle_oe", serial_readback_oe_o, 0);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (dac_load_o === 1'b1) dl++;
    if (frame_done_o === 1'b1) fd++;
    if (clear_load_o === 1'b1) begin
      cl++;
      cl_val = clear_value_o;
    end
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    step(20);
    check("busy_in_reset", busy_n_o, 0);
    check("regs_reset", regs_reset_o, 1);
    nrst_i = 1'b1;
    wait_busy();
    check("por_len", n >= RST && n <= RST + 8, 1);
    foreach (sels[i]) begin
      mon_sel_i = sels[i];
      int_ref_sel_i = i[0];
      step(2);
      check("mon_sel", monitor_output_sel_o, sels[i]);
      check("mon_en", mon_path_en_o, 1);
      check("ref_oe", reference_pin_oe_o, i[0]);
    end
    mon_sel_i = 5'h12;
    step(2);
    check("mon_bad_sel", mon_path_en_o, 0);
    mon_sel_i = 5'h03;
    mon_en_i = 1'b0;
    step(2);
    check("mon_off", mon_path_en_o, 0);
    mon_en_i = 1'b1;
    $display("reset and monitor tests done");
    frame(24'hFF_FFFF, 1'b0);
    check("sdo_chain_off", host_u.rd_word, 0);
    chain_enable_addr_bit1_i = 1'b1;
    frame(24'h5A_3C96, 1'b1);
    check("sdo_chain_on", host_u.rd_word, 24'hFF_FFFF);
    frame(24'hC3_0F0F, 1'b0);
    check("sdo_chain_word", host_u.rd_word, 24'h5A_3C96);
    d0 = dl;
    pulse_load();
    step(3);
    check("load_idle", dl, d0 + 1);
    $display("serial and load tests done");
    clear_to_code_n_i = 1'b0;
    step(4);
    check("clear_cnt", cl, 1);
    check("clear_val", cl_val, 14'h2A5C);
    wait_busy();
    check("clear_len", n >= 490 && n <= 502, 1);
    d0 = dl;
    pulse_load();
    step(6);
    check("load_in_clear", dl, d0);
    clear_to_code_n_i = 1'b1;
    step(4);
    $display("clear test done");
    reset_n_i = 1'b0;
    step(5);
    check("pin_reset", regs_reset_o, 1);
    d0 = dl;
    pulse_load();
    wait_busy();
    check("pin_reset_len", n + 8 >= RST - 4 && n + 8 <= RST + 4, 1);
    step(6);
    check("load_in_reset", dl, d0);
    step(100);
    check("level_ignored", busy_n_o, 1);
    reset_n_i = 1'b1;
    step(4);
    $display("reset pin test done");
    if_sel_i = 1'b0;
    step(4);
    check("addr_bits", bus_addr_bits_o, 2'b10);
    d0 = fd;
    fork
      host_u.send(24'h12_3456);
    join_none
    step(220);
    check("two_wire_frame", fd, d0);
    $display("two-wire test done");
    finish_test();
  end
endmodule
